// file: design/tec_pkg.sv
// Notes on behaviour
// - Eight-bit counter, counts upward only.
// - Prescale code divides internal clock by 2..256.
// - Edge bit: 0 rising, 1 falling.
// - Enable bit gates all counting.
// - Mode: unused, event, timer, pulse width.
// - Tone frequency equals fint over 2(256-N).
// - Write sets preload, read returns count.
// - Event mode counts active pin edges.
// - Timer mode counts prescaled clock ticks.
// - Overflow reloads preload and sets flag.
// - Pulse mode counts between edges, clears enable.
// - Result held until enable set again.
// - Pulse start needs an edge, not level.
// - Hardware clears enable only in pulse mode.
// - Overflow is a wake-up source.
// - Cleared interrupt enable suppresses the request.
// - Write while off also loads counter.
// - Counter read blocks the counting clock.
// - Prescaler source is system or crystal clock.
// - Control resets to 0x08 on cold reset.
// - Tone pins gated by port B bit 0.
package tec_pkg;
   // Register addresses in data memory
   localparam logic [7:0] ADDR_COUNT = 8'h0d;
   localparam logic [7:0] ADDR_CTRL = 8'h0e;
   // Reset values and counter maximum
   localparam logic [7:0] CTRL_RESET = 8'h08;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hff;
   // Control field positions
   localparam int PRESCALE_LSB = 0;
   localparam int PRESCALE_W = 3;
   localparam int EDGE_BIT = 3;
   localparam int ENABLE_BIT = 4;
   localparam int RSVD_BIT = 5;
   localparam int MODE_LSB = 6;
   // Flag position in the interrupt control register outside
   localparam int IRQ_FLAG_BIT = 5;
   // Prescaler depth: 8 stages gives up to /256
   localparam int PRESCALE_STAGES = 8;
   // Operating modes
   localparam logic [1:0] MODE_UNUSED = 2'h0;
   localparam logic [1:0] MODE_EVENT = 2'h1;
   localparam logic [1:0] MODE_TIMER = 2'h2;
   localparam logic [1:0] MODE_PULSE = 2'h3;
   // Control register layout, msb first
   typedef struct packed {
      logic [1:0] mode;
      logic rsvd;
      logic enable;
      logic edge_fall;
      logic [PRESCALE_W-1:0] prescale;
   } tec_ctrl_t;
   // Pulse width measurement states
   typedef enum logic [0:0] {
      TEC_PW_WAIT,
      TEC_PW_COUNT
   } tec_pw_state_t;
endpackage

// file: design/tec_prescale.sv
`timescale 1ns/1ps
`default_nettype none
module tec_prescale #(
   parameter bit USE_RTC = 1'b0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Crystal clock pin, asynchronous
   input wire logic rtc_clk_i,
   // Division code
   input wire logic [tec_pkg::PRESCALE_W-1:0] sel_i,
   // One-cycle tick at the divided rate
   output logic tick_o
);
   logic [2:0] rtc_sync; // Two-flop sync plus one edge stage
   logic [2:0] next_rtc_sync;
   logic [tec_pkg::PRESCALE_STAGES-1:0] div; // Free-running synchronous binary count
   logic [tec_pkg::PRESCALE_STAGES-1:0] next_div;
   logic [tec_pkg::PRESCALE_STAGES-1:0] mask;
   logic src_tick;

   // Source tick and divider next values
   always_comb begin
      next_rtc_sync = {rtc_sync[1:0], rtc_clk_i};
      // Crystal edges are counted on the system clock, so it must be far faster
      src_tick = USE_RTC ? (rtc_sync[1] & ~rtc_sync[2]) : 1'b1;
      mask = 8'hff >> (3'd7 - sel_i);
      tick_o = src_tick & (&(div | ~mask));
      next_div = src_tick ? div + 8'h01 : div;
   end

   // Register divider; cleared by reset
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rtc_sync <= 3'h0;
         div <= 8'h00;
      end else begin
         rtc_sync <= next_rtc_sync;
         div <= next_div;
      end
   end
endmodule
`default_nettype wire

// file: design/tec_top.sv
`timescale 1ns/1ps
`default_nettype none
module tec_top #(
   parameter bit USE_RTC = 1'b0,   // Build option: crystal feeds prescaler
   parameter bit BUZZER_OPT = 1'b1 // Build option: tone pins active
) (
   // Clock and reset
   input wire logic MCLK_I,
   input wire logic RST_I,
   // Data-memory register port
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   // Pins from outside, asynchronous
   input wire logic TIMER_COUNT_OR_INPUT_PIN_I,
   input wire logic RTC_CLK_I,
   // Interrupt control bits held outside
   input wire logic OVERFLOW_IRQ_ENABLE_I,
   input wire logic FLAG_CLR_I,
   output logic OVERFLOW_IRQ_FLAG_O,
   output logic OVERFLOW_IRQ_REQ_O,
   // Wake-up from halt
   output logic WAKEUP_O,
   // Tone outputs
   input wire logic PORT_B_BIT0_I,
   output logic OVERFLOW_FREQ_OUTPUT_O,
   output logic BUZZER_OUT_O,
   output logic BUZZER_OUT_N_O
);
   tec_pkg::tec_ctrl_t ctrl; // Control register
   tec_pkg::tec_ctrl_t next_ctrl;
   logic [7:0] count; // Live counter
   logic [7:0] next_count;
   logic [7:0] preload; // Reload value
   logic [7:0] next_preload;
   tec_pkg::tec_pw_state_t pw_state; // Pulse width tracker
   tec_pkg::tec_pw_state_t next_pw_state;
   logic [2:0] pin_sync; // Two-flop sync plus edge stage
   logic [2:0] next_pin_sync;
   logic [7:0] next_rdata;
   logic next_flag;
   logic next_irq_req;
   logic next_freq;
   logic next_bz;
   logic next_bz_n;
   logic fint_tick; // Prescaled internal tick
   logic rise; // Synchronised pin edges
   logic fall;
   logic act_edge; // Selected start edge
   logic ret_edge; // Edge back to original level
   logic wr_count; // Register strobes
   logic wr_ctrl;
   logic rd_block;
   logic cnt_tick; // Counter advances this cycle
   logic overflow;

   // Option check, declared ahead of its use at elaboration
   function automatic bit PRESCALE_CHECK_FAIL(input bit a, input bit b);
      return (a !== 1'b0 && a !== 1'b1) || (b !== 1'b0 && b !== 1'b1);
   endfunction

   generate
      if (PRESCALE_CHECK_FAIL(USE_RTC, BUZZER_OPT)) begin : g_bad
         $error("tec_top: unsupported option");
      end
   endgenerate

   // Prescaler on system or crystal clock
   tec_prescale #(
      .USE_RTC(USE_RTC)
   ) u_prescale (
      .clk_i(MCLK_I),
      .rst_i(RST_I),
      .rtc_clk_i(RTC_CLK_I),
      .sel_i(ctrl.prescale),
      .tick_o(fint_tick)
   );

   // Edge detection looks only at the second and third stages
   always_comb begin
      next_pin_sync = {pin_sync[1:0], TIMER_COUNT_OR_INPUT_PIN_I};
      rise = pin_sync[1] & ~pin_sync[2];
      fall = ~pin_sync[1] & pin_sync[2];
      act_edge = ctrl.edge_fall ? fall : rise;
      ret_edge = ctrl.edge_fall ? rise : fall;
   end

   // Register strobes and count tick selection
   always_comb begin
      wr_count = WR_I && (ADDR_I == tec_pkg::ADDR_COUNT);
      wr_ctrl = WR_I && (ADDR_I == tec_pkg::ADDR_CTRL);
      // Reading the counter blocks its clock; the lost count is accepted
      rd_block = RD_I && (ADDR_I == tec_pkg::ADDR_COUNT);
      case (ctrl.mode)
         tec_pkg::MODE_EVENT: cnt_tick = act_edge;
         tec_pkg::MODE_TIMER: cnt_tick = fint_tick;
         tec_pkg::MODE_PULSE: cnt_tick = fint_tick && (pw_state == tec_pkg::TEC_PW_COUNT);
         default: cnt_tick = 1'b0;
      endcase
      cnt_tick = cnt_tick && ctrl.enable && !rd_block;
      overflow = cnt_tick && (count == tec_pkg::COUNT_MAX);
   end

   // Next state of control, counter, pulse tracker and outputs
   always_comb begin
      next_ctrl = ctrl;
      next_count = count;
      next_preload = preload;
      next_pw_state = pw_state;
      // Counter: up only, reload on overflow
      if (cnt_tick) begin
         next_count = overflow ? preload : count + 8'h01;
      end
      // Pulse width tracker; leaving enable or mode rearms it
      if (!(ctrl.enable && ctrl.mode == tec_pkg::MODE_PULSE)) begin
         // A finished measurement waits here, result held, until enable is set again
         next_pw_state = tec_pkg::TEC_PW_WAIT;
      end else begin
         case (pw_state)
            tec_pkg::TEC_PW_WAIT: begin
               // Only an edge starts it, never a standing level
               if (act_edge) begin
                  next_pw_state = tec_pkg::TEC_PW_COUNT;
               end
            end
            default: begin
               if (ret_edge) begin
                  next_pw_state = tec_pkg::TEC_PW_WAIT;
                  next_ctrl.enable = 1'b0;
               end
            end
         endcase
      end
      // Register writes; a control write wins over the hardware clear
      if (wr_count) begin
         next_preload = WDATA_I;
         if (!ctrl.enable) begin
            next_count = WDATA_I;
         end
      end
      if (wr_ctrl) begin
         next_ctrl = tec_pkg::tec_ctrl_t'(WDATA_I);
         next_ctrl.rsvd = 1'b0;
      end
      // Flag: set beats clear
      next_flag = OVERFLOW_IRQ_FLAG_O;
      if (FLAG_CLR_I) begin
         next_flag = 1'b0;
      end
      if (overflow) begin
         next_flag = 1'b1;
      end
      next_irq_req = next_flag && OVERFLOW_IRQ_ENABLE_I;
      next_freq = OVERFLOW_FREQ_OUTPUT_O ^ overflow;
      next_bz = BUZZER_OPT && next_freq && PORT_B_BIT0_I;
      next_bz_n = BUZZER_OPT && !next_freq && PORT_B_BIT0_I;
      // Read data: counter, control, or zero elsewhere
      next_rdata = RDATA_O;
      if (RD_I) begin
         if (ADDR_I == tec_pkg::ADDR_COUNT) begin
            next_rdata = count;
         end else if (ADDR_I == tec_pkg::ADDR_CTRL) begin
            next_rdata = {ctrl.mode, 1'b0, ctrl.enable, ctrl.edge_fall, ctrl.prescale};
         end else begin
            next_rdata = 8'h00;
         end
      end
   end

   // Cold reset; a warm wake from halt never drives RST_I, so state is kept
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         ctrl <= tec_pkg::tec_ctrl_t'(tec_pkg::CTRL_RESET);
         count <= tec_pkg::COUNT_RESET;
         preload <= tec_pkg::COUNT_RESET;
         pw_state <= tec_pkg::TEC_PW_WAIT;
         pin_sync <= 3'h0;
         RDATA_O <= 8'h00;
         OVERFLOW_IRQ_FLAG_O <= 1'b0;
         OVERFLOW_IRQ_REQ_O <= 1'b0;
         WAKEUP_O <= 1'b0;
         OVERFLOW_FREQ_OUTPUT_O <= 1'b0;
         BUZZER_OUT_O <= 1'b0;
         BUZZER_OUT_N_O <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         count <= next_count;
         preload <= next_preload;
         pw_state <= next_pw_state;
         pin_sync <= next_pin_sync;
         RDATA_O <= next_rdata;
         OVERFLOW_IRQ_FLAG_O <= next_flag;
         OVERFLOW_IRQ_REQ_O <= next_irq_req;
         WAKEUP_O <= overflow;
         OVERFLOW_FREQ_OUTPUT_O <= next_freq;
         BUZZER_OUT_O <= next_bz;
         BUZZER_OUT_N_O <= next_bz_n;
      end
   end

   // Checks on the counter and its side effects
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (RST_I);

   a_count_up_step: assert property (cnt_tick && count != tec_pkg::COUNT_MAX |=>
      count == $past(count) + 8'h01) else $error("counter did not step by one");
   a_count_hold: assert property (!cnt_tick && !wr_count |=> $stable(count))
      else $error("counter moved without a tick");
   a_ovf_reload: assert property (overflow |=> count == $past(preload))
      else $error("overflow did not reload");
   a_ovf_flag_set: assert property (overflow |=> OVERFLOW_IRQ_FLAG_O && WAKEUP_O)
      else $error("overflow flag or wake missing");
   a_freq_toggle: assert property (overflow |=>
      OVERFLOW_FREQ_OUTPUT_O != $past(OVERFLOW_FREQ_OUTPUT_O)) else $error("tone not toggled");
   a_read_block: assert property (rd_block |-> !cnt_tick)
      else $error("counted during a read");
   a_off_write_load: assert property (wr_count && !ctrl.enable |=>
      count == $past(WDATA_I) && preload == $past(WDATA_I)) else $error("write while off");
   a_rsvd_zero: assert property (ctrl.rsvd == 1'b0)
      else $error("reserved control bit set");
   a_event_edge: assert property (ctrl.enable && ctrl.mode == tec_pkg::MODE_EVENT &&
      act_edge && !rd_block |-> cnt_tick) else $error("event edge not counted");
   a_pw_stop: assert property (pw_state == tec_pkg::TEC_PW_COUNT && ret_edge &&
      ctrl.enable && ctrl.mode == tec_pkg::MODE_PULSE && !wr_ctrl |=>
      !ctrl.enable ##1 pw_state == tec_pkg::TEC_PW_WAIT) else $error("pulse end missed");
   a_irq_gate: assert property (!OVERFLOW_IRQ_ENABLE_I |=> !OVERFLOW_IRQ_REQ_O)
      else $error("request with enable low");

   c_event_overflow: cover property (overflow && ctrl.mode == tec_pkg::MODE_EVENT);
   c_timer_overflow: cover property (overflow && ctrl.mode == tec_pkg::MODE_TIMER);
   c_pulse_done: cover property (pw_state == tec_pkg::TEC_PW_COUNT ##1
      pw_state == tec_pkg::TEC_PW_WAIT && !ctrl.enable);
   c_read_block: cover property (rd_block && fint_tick && ctrl.enable);
endmodule
`default_nettype wire

// file: bench/tec_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// Source on the timer pin: one high pulse of a commanded length
module tec_pin_model (
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [7:0] width_i,
   output logic pin_o
);
   // Cycles of high level still to run
   logic [7:0] left;
   // Pulse stays high width_i cycles; long widths keep edges apart for the synchroniser
   always @(posedge clk_i) begin
      if (go_i) begin
         left <= width_i;
         pin_o <= 1'b1;
      end else if (left > 8'h01) begin
         left <= left - 8'h01;
      end else begin
         pin_o <= 1'b0;
      end
   end
   // Idle low before the first pulse
   initial pin_o = 1'b0;
   initial left = 8'h00;
endmodule
`default_nettype wire

// file: bench/timer_event_counter_8bit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module timer_event_counter_8bit_tb;
   // Bench clock, register port and pin controls
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0;
   logic ien = 1'b1, fclr = 1'b0, pb0 = 1'b1, pin;
   logic [7:0] addr = 8'h00, wdata = 8'h00, width = 8'h00, rdata, v, w;
   logic flag, req, wake, freq, bz, bzn;
   int num_errors = 0, checks_done = 0, n;
   always #50 clk = ~clk;
   // Crystal input tied low, the system clock feeds the prescaler
   tec_top dut_u (.MCLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdata), .TIMER_COUNT_OR_INPUT_PIN_I(pin), .RTC_CLK_I(1'b0),
      .OVERFLOW_IRQ_ENABLE_I(ien), .FLAG_CLR_I(fclr), .OVERFLOW_IRQ_FLAG_O(flag),
      .OVERFLOW_IRQ_REQ_O(req), .WAKEUP_O(wake), .PORT_B_BIT0_I(pb0),
      .OVERFLOW_FREQ_OUTPUT_O(freq), .BUZZER_OUT_O(bz), .BUZZER_OUT_N_O(bzn));
   tec_pin_model pin_u (.clk_i(clk), .go_i(go), .width_i(width), .pin_o(pin));
   // Verdict and end of run
   task automatic conclude;
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // One comparison, four-state exact
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Wait a fixed number of cycles
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // One-cycle write strobe
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // One-cycle read strobe, data settled after the sampling edge
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   // Start a pin pulse without waiting for it to end
   task automatic pls(input logic [7:0] k);
      @(posedge clk);
      go <= 1'b1;
      width <= k;
      @(posedge clk);
      go <= 1'b0;
   endtask
   // Cycles until the next wake pulse; running out is a failure
   task automatic wait_wake(output int k);
      for (k = 1; k < 600; k++) begin
         @(posedge clk);
         #1;
         if (wake === 1'b1) return;
      end
      chk("wake timeout", 8'h01, 8'h00);
      conclude();
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_reg(8'h0e, v); chk("ctrl reset", 8'h08, v);
      rd_reg(8'h0d, v); chk("count reset", 8'h00, v);
      rd_reg(8'h33, v); chk("unmapped", 8'h00, v);
      wr_reg(8'h0e, 8'h20); rd_reg(8'h0e, v); chk("bit5", 8'h00, v);
      // Event mode, rising edges, three counts to overflow
      wr_reg(8'h0e, 8'h40); wr_reg(8'h0d, 8'hfd);
      rd_reg(8'h0d, v); chk("load off", 8'hfd, v);
      wr_reg(8'h0e, 8'h50);
      repeat (3) begin
         pls(8'h04); cyc(10);
      end
      rd_reg(8'h0d, v); chk("reload", 8'hfd, v);
      chk("flag", 8'h01, {7'h00, flag});
      chk("req", 8'h01, {7'h00, req});
      chk("freq", 8'h01, {7'h00, freq});
      chk("buzz pair", 8'h02, {6'h00, bz, bzn});
      ien <= 1'b0; pb0 <= 1'b0; fclr <= 1'b1; cyc(3);
      chk("req off", 8'h00, {7'h00, req});
      chk("buzz gated", 8'h00, {6'h00, bz, bzn});
      chk("flag cleared", 8'h00, {7'h00, flag});
      fclr <= 1'b0;
      // Falling-edge select: the high half of a pulse does not count
      wr_reg(8'h0e, 8'h58);
      pls(8'h1e); cyc(12);
      rd_reg(8'h0d, v); chk("no rise count", 8'hfd, v);
      cyc(30);
      rd_reg(8'h0d, v); chk("fall count", 8'hfe, v);
      wr_reg(8'h0d, 8'h10);
      rd_reg(8'h0d, v); chk("load on", 8'hfe, v);
      wr_reg(8'h0e, 8'h48); cyc(2);
      pls(8'h06); cyc(12);
      rd_reg(8'h0d, v); chk("gated off", 8'hfe, v);
      // Timer mode with preload ff: every tick overflows
      wr_reg(8'h0e, 8'h80); wr_reg(8'h0d, 8'hff);
      for (int c = 0; c < 8; c++) begin
         wr_reg(8'h0e, 8'h90 | 8'(c));
         wait_wake(n); wait_wake(n);
         chk("tick period", 8'(1 << (c + 1)), 8'(n));
      end
      // Pulse width: 20 cycles high at divide by 2 gives about 10
      wr_reg(8'h0e, 8'hc0); wr_reg(8'h0d, 8'h00); wr_reg(8'h0e, 8'hd0);
      pls(8'h14); cyc(30);
      rd_reg(8'h0d, v);
      chk("width", 8'h01, {7'h00, v >= 8'h09 && v <= 8'h0b});
      rd_reg(8'h0e, w); chk("enable cleared", 8'hc0, w);
      pls(8'h14); cyc(30);
      rd_reg(8'h0d, w); chk("held", v, w);
      // Rearm while pin already high: only its return edge follows
      pls(8'h28); cyc(10);
      wr_reg(8'h0e, 8'hd0); cyc(40);
      rd_reg(8'h0d, w); chk("level no start", v, w);
      rd_reg(8'h0e, w); chk("still armed", 8'hd0, w);
      conclude();
   end
endmodule
`default_nettype wire
